/* inc/afc_params.svh */
// Constants for the automatic flow control block
// Operation
// [RULE1] No pause frame or jam while the transmitter is disabled.
// [RULE2] High threshold bits 23:16 in 64-byte units triggers flow control.
// [RULE3] Full duplex: one pause frame with programmed pause time per high event.
// [RULE4] Half duplex: jam each matching incoming frame for the selected duration.
// [RULE5] Low threshold bits 15:8; falling below it sends zero-time pause.
// [RULE6] Zero pause only if enabled, high was reached and pause was sent.
// [RULE7] Software keeps low threshold below high threshold when enabled.
// [RULE8] Duration code bits 7:4 sets jam length; unused in full duplex.
// [RULE9] Bit 3 jams multicast frames above high level; half duplex only.
// [RULE10] Bit 2 jams broadcast frames above high level; half duplex only.
// [RULE11] Bit 1 jams own-address frames above high level; half duplex only.
// [RULE12] All fields reset to zero; bits 31:24 reserved, read zero.
// [RULE13] Bit 0 acts on any frame, overrides 3:1, jams on preamble, pauses now.
// [RULE14] Jam lengths 5,10,15,25 then 50..600 us; plus 2.2 us at 10 Mb/s.
// [RULE15] Compare FIFO bytes with threshold times 64 each clock; track pause.
`ifndef AFC_PARAMS_SVH
`define AFC_PARAMS_SVH
`define AFC_CONFIG_ADDR  8'h00
`define AFC_HIGH_MSB     23
`define AFC_HIGH_LSB     16
`define AFC_LOW_MSB      15
`define AFC_LOW_LSB      8
`define AFC_DUR_MSB      7
`define AFC_DUR_LSB      4
`define AFC_BIT_MULT     3
`define AFC_BIT_BRD      2
`define AFC_BIT_ADD      1
`define AFC_BIT_ANY      0
`define AUTO_FLOW_CTRL_CONFIG_MASK     32'h00FFFFFF
`define AFC_UNIT_SHIFT   6
`define AFC_CLK_MHZ      100
`define AFC_SLOW_EXTRA_NS 2200
`define AFC_JAM_STEP_US   5
`define AFC_JAM_CODE3_US  25
`define AFC_JAM_LONG_US   50
`define AFC_JAM_LONG_BASE 3
`endif

/* inc/afc_pkg.sv */
// Types shared by the automatic flow control block
package afc_pkg;
    typedef struct packed {
        logic       valid;
        logic       multicast;
        logic       broadcast;
        logic       ownAddr;
    } rx_frame_t;
    typedef struct packed {
        logic       fullDuplex;
        logic       speed100;
        logic       txEnable;
    } link_mode_t;
    typedef enum logic [1:0] { PAUSE_IDLE, PAUSE_HELD } pause_state_t;
endpackage

/* rtl/afc_jam_timer.sv */
// Back pressure duration timer
`timescale 1ns/1ps
`include "afc_params.svh"
module afc_jam_timer #(
    parameter int CNT_W = 17
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       start,
    input  wire logic [3:0] code,
    input  wire logic       speed100,
    input  wire logic       abort,
    // Status
    output logic            busy
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] load;
    logic [15:0]      us;

    // Code to microseconds: 5,10,15,25 then 50 us steps
    always_comb begin
        if (code < 4'(`AFC_JAM_LONG_BASE)) begin
            us = 16'(`AFC_JAM_STEP_US * (32'(code) + 1));
        end else if (code == 4'(`AFC_JAM_LONG_BASE)) begin
            us = 16'(`AFC_JAM_CODE3_US);
        end else begin
            us = 16'(`AFC_JAM_LONG_US * (32'(code) - `AFC_JAM_LONG_BASE));
        end
    end
    // Slow link adds a fixed extra span
    assign load = CNT_W'(32'(us) * `AFC_CLK_MHZ
        + (speed100 ? 0 : `AFC_SLOW_EXTRA_NS * `AFC_CLK_MHZ / 1000)); // [RULE14]

    // Down counter; restart wins over a running count
    always_ff @(posedge core_clk) begin
        if (!rst_n || abort) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= load;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    assign busy = (cnt_q != '0);
endmodule // afc_jam_timer

/* rtl/auto_flow_ctrl_config_regs.sv */
// Configuration register for automatic flow control
`timescale 1ns/1ps
`include "afc_params.svh"
module auto_flow_ctrl_config_regs (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    // Configuration out
    output logic      [23:0] cfg
);
    logic [23:0] cfg_q;

    // Writable fields; reserved top byte never stored
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_q <= '0; // [RULE12]
        end else if (regWr && regAddr == `AFC_CONFIG_ADDR) begin
            cfg_q <= regWdata[23:0];
        end
    end
    // Read data one cycle later; unmapped reads return zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (regRd && regAddr == `AFC_CONFIG_ADDR) begin
            regRdata <= {8'h00, cfg_q} & `AUTO_FLOW_CTRL_CONFIG_MASK; // [RULE12]
        end else begin
            regRdata <= '0;
        end
    end
    assign cfg = cfg_q;
endmodule // auto_flow_ctrl_config_regs

/* rtl/auto_flow_control.sv */
// Automatic receive flow control: thresholds, pause requests, jam
`timescale 1ns/1ps
`include "afc_params.svh"
module auto_flow_control #(
    parameter int FILL_W = 14
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // Register port
    input  wire logic [7:0]             regAddr,
    input  wire logic [31:0]            regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic      [31:0]            regRdata,
    // Receive side
    input  wire logic [FILL_W-1:0]      rxFifoBytes,
    input  wire logic                   rxPreamble,
    input  wire afc_pkg::rx_frame_t     rxFrame,
    input  wire afc_pkg::link_mode_t    linkMode,
    // Actions toward the MAC
    input  wire logic [15:0]            pause_time_value,
    output logic                        pauseReq,
    output logic      [15:0]            pauseTime,
    output logic                        jamActive,
    output logic                        aboveHigh
);
    import afc_pkg::*;

    logic [23:0]       cfg;
    logic [FILL_W+1:0] hiBytes;
    logic [FILL_W+1:0] loBytes;
    logic [FILL_W+1:0] fillExt;
    logic              reachHigh;
    logic              belowLow;
    logic              anyEn;
    logic              matchEn;
    logic              fd;
    logic              txOn;
    logic              jamStart;
    logic              jamBusy;
    logic              highSeen_q;
    logic              pauseReq_q;
    logic [15:0]       pauseTime_q;
    pause_state_t      state_q;
    logic [3:0]        durCode;

    auto_flow_ctrl_config_regs uRegs (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .regAddr  (regAddr),
        .regWdata (regWdata),
        .regWr    (regWr),
        .regRd    (regRd),
        .regRdata (regRdata),
        .cfg      (cfg)
    );

    // Thresholds scaled to bytes; widened so 255*64 never wraps
    assign hiBytes = (FILL_W+2)'(cfg[`AFC_HIGH_MSB:`AFC_HIGH_LSB])
        << `AFC_UNIT_SHIFT; // [RULE2] [RULE15]
    assign loBytes = (FILL_W+2)'(cfg[`AFC_LOW_MSB:`AFC_LOW_LSB])
        << `AFC_UNIT_SHIFT; // [RULE5] [RULE15]
    assign fillExt   = (FILL_W+2)'(rxFifoBytes);
    assign reachHigh = fillExt >= hiBytes; // [RULE15]
    assign belowLow  = fillExt < loBytes; // [RULE5]
    assign fd        = linkMode.fullDuplex;
    assign txOn      = linkMode.txEnable;
    assign anyEn     = cfg[`AFC_BIT_ANY];
    // Frame-type enables only count when the any-frame bit is clear
    assign matchEn   = (cfg[`AFC_BIT_MULT] && rxFrame.multicast) // [RULE9]
                    || (cfg[`AFC_BIT_BRD] && rxFrame.broadcast) // [RULE10]
                    || (cfg[`AFC_BIT_ADD] && rxFrame.ownAddr); // [RULE11]
    assign durCode   = cfg[`AFC_DUR_MSB:`AFC_DUR_LSB]; // [RULE8]
    assign aboveHigh = highSeen_q;

    // Level memory: set on high, cleared once fill drops below low
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            highSeen_q <= 1'b0;
        end else if (reachHigh) begin
            highSeen_q <= 1'b1; // [RULE15]
        end else if (belowLow) begin
            highSeen_q <= 1'b0;
        end
    end

    // Half duplex jam on preamble (any) or on a matching frame
    assign jamStart = txOn && !fd && highSeen_q
        && (anyEn ? rxPreamble // [RULE13]
                  : (rxFrame.valid && matchEn)); // [RULE4] [RULE1]

    afc_jam_timer uJam (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (jamStart),
        .code     (durCode),
        .speed100 (linkMode.speed100),
        .abort    (!txOn || fd), // [RULE1] [RULE8]
        .busy     (jamBusy)
    );
    assign jamActive = jamBusy && txOn; // [RULE1]

    // Full duplex pause tracking: one pause per high event, then zero pause
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= PAUSE_IDLE;
        end else begin
            case (state_q)
                PAUSE_IDLE: begin
                    if (txOn && fd && anyEn && reachHigh) begin
                        state_q <= PAUSE_HELD; // [RULE3] [RULE13]
                    end
                end
                PAUSE_HELD: begin
                    if (belowLow || !txOn) begin
                        state_q <= PAUSE_IDLE; // [RULE6]
                    end
                end
                default: begin
                    state_q <= PAUSE_IDLE;
                end
            endcase
        end
    end

    // Pause request pulse and its pause time
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pauseReq_q  <= 1'b0;
            pauseTime_q <= 16'h0000;
        end else if (state_q == PAUSE_IDLE && txOn && fd && anyEn
                     && reachHigh) begin
            pauseReq_q  <= 1'b1; // [RULE3]
            pauseTime_q <= pause_time_value;
        end else if (state_q == PAUSE_HELD && belowLow && txOn && anyEn) begin
            pauseReq_q  <= 1'b1; // [RULE5] [RULE6]
            pauseTime_q <= 16'h0000;
        end else begin
            pauseReq_q  <= 1'b0;
        end
    end
    assign pauseReq  = pauseReq_q;
    assign pauseTime = pauseTime_q;

    // Checks
    sequence sHighPause;
        txOn && fd && anyEn && reachHigh && state_q == PAUSE_IDLE;
    endsequence

    chk_pause_on_high: assert property (@(posedge core_clk) // [RULE3]
        disable iff (!rst_n) sHighPause |=> pauseReq
            && pauseTime == $past(pause_time_value))
        else $error("pause not sent on high");

    chk_single_pause: assert property (@(posedge core_clk) // [RULE3]
        disable iff (!rst_n) pauseReq && pauseTime != 16'h0000
            |=> !pauseReq || pauseTime == 16'h0000)
        else $error("second pause in one high event");

    chk_zero_pause: assert property (@(posedge core_clk) // [RULE5]
        disable iff (!rst_n)
        state_q == PAUSE_HELD && belowLow && txOn && anyEn
            |=> pauseReq && pauseTime == 16'h0000)
        else $error("zero pause missing");

    chk_zero_needs_held: assert property (@(posedge core_clk) // [RULE6]
        disable iff (!rst_n) pauseReq && pauseTime == 16'h0000
            |-> $past(state_q) == PAUSE_HELD)
        else $error("zero pause without earlier pause");

    chk_tx_off_quiet: assert property (@(posedge core_clk) // [RULE1]
        disable iff (!rst_n) !txOn |=> !jamBusy)
        else $error("jam with transmitter off");

    chk_no_pause_off: assert property (@(posedge core_clk) // [RULE1]
        disable iff (!rst_n) pauseReq |-> $past(txOn))
        else $error("pause with transmitter off");

    chk_jam_start: assert property (@(posedge core_clk) // [RULE4]
        disable iff (!rst_n) jamStart ##1 (txOn && !fd) |-> jamActive)
        else $error("jam did not start");

    chk_fd_no_jam: assert property (@(posedge core_clk) // [RULE8]
        disable iff (!rst_n) fd ##1 fd |-> !jamActive)
        else $error("jam in full duplex");

    chk_reserved_zero: assert property (@(posedge core_clk) // [RULE12]
        disable iff (!rst_n) regRdata[31:24] == 8'h00)
        else $error("reserved bits not zero");
endmodule // auto_flow_control

/* tb/link_partner_model.sv */
// Far-side model: frame arrivals and bookkeeping of pause frames
`timescale 1ns/1ps
module link_partner_model (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // Bench stimulus
    input  wire logic                sendFrame,
    input  wire logic [2:0]          kind,
    // Toward the block
    output logic                     rxPreamble,
    output afc_pkg::rx_frame_t       rxFrame,
    // Pause frames received
    input  wire logic                pauseReq,
    input  wire logic [15:0]         pauseTime,
    output logic      [7:0]          pauseCount,
    output logic      [15:0]         lastPause
);
    import afc_pkg::*;
    logic [2:0] gap_q;

    // Preamble first; the header decodes a few cycles later
    always_ff @(posedge core_clk) begin
        rxPreamble <= rst_n & sendFrame;
        if (!rst_n || sendFrame)
            gap_q <= rst_n ? 3'h4 : 3'h0;
        else if (gap_q != 3'h0)
            gap_q <= gap_q - 3'h1;
        rxFrame <= '{gap_q == 3'h1, kind[2], kind[1], kind[0]};
    end

    // Count pause frames; the time of the last one is kept for checks
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pauseCount <= 8'h00;
            lastPause  <= 16'h0000;
        end else if (pauseReq) begin
            pauseCount <= pauseCount + 8'h01;
            lastPause  <= pauseTime;
        end
    end
endmodule // link_partner_model

/* tb/testbench.sv */
// Self-checking bench for automatic flow control
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin n_compared++; \
    if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module testbench;
    import afc_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdata;
    logic [13:0] rxFifoBytes = 14'h0;
    logic        rxPreamble;
    rx_frame_t   rxFrame;
    link_mode_t  linkMode = '{1'b1, 1'b1, 1'b1};
    logic [15:0] pauseTime;
    logic [15:0] pauseTimeValue = 16'h1234;
    logic        pauseReq, jamActive, aboveHigh, sendFrame = 1'b0;
    logic [2:0]  kind = 3'h0;
    logic [7:0]  pauseCount;
    logic [15:0] lastPause;
    int          num_errors = 0;
    int          n_compared = 0;

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    auto_flow_control auto_flow_control_i (.core_clk(core_clk),
        .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .rxFifoBytes(rxFifoBytes), .rxPreamble(rxPreamble),
        .rxFrame(rxFrame), .linkMode(linkMode),
        .pause_time_value(pauseTimeValue), .pauseReq(pauseReq),
        .pauseTime(pauseTime), .jamActive(jamActive),
        .aboveHigh(aboveHigh));
    link_partner_model link_partner_model_i (.core_clk(core_clk),
        .rst_n(rst_n), .sendFrame(sendFrame), .kind(kind),
        .rxPreamble(rxPreamble), .rxFrame(rxFrame), .pauseReq(pauseReq),
        .pauseTime(pauseTime), .pauseCount(pauseCount),
        .lastPause(lastPause));

    // Register bus cycles: one-cycle strobes, read data one cycle later
    task automatic regWrite(input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= 8'h00;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic setFill(input int v, input int n);
        @(posedge core_clk);
        rxFifoBytes <= 14'(v);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Send one frame and measure how long back pressure stands
    task automatic jamLen(input logic [2:0] k, output int n);
        n = 0;
        @(posedge core_clk);
        kind <= k;
        sendFrame <= 1'b1;
        @(posedge core_clk);
        sendFrame <= 1'b0;
        #1;
        for (int w = 0; w < 20 && jamActive !== 1'b1; w++) begin
            @(posedge core_clk);
            #1;
        end
        while (jamActive === 1'b1 && n < 70000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask
    // Jam length in cycles; slow links add 2.2 us
    function automatic int durCycles(input int c, input logic s100);
        int us[4] = '{5, 10, 15, 25};
        durCycles = (c < 4 ? us[c] : (c - 3) * 50) * 100 + (s100 ? 0 : 220);
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 13k cycles
    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        int n;
        logic [31:0] d;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        regRead(8'h00, d);
        `CHECK("cfg reset", 32'h0, d)
        regWrite(32'hFFFFFFFF);
        regRead(8'h00, d);
        `CHECK("cfg readback", 32'h00FFFFFF, d)
        regRead(8'h44, d);
        `CHECK("unmapped read", 32'h0, d)
        // Full duplex: high 256 bytes, low 128 bytes, any frame
        regWrite(32'h00040201);
        `CHECK("no unearned resume", 8'h00, pauseCount)
        setFill(255, 4);
        `CHECK("below high", 8'h00, pauseCount)
        setFill(256, 3);
        `CHECK("pause sent", 8'h01, pauseCount)
        `CHECK("pause time", 16'h1234, lastPause)
        `CHECK("above high", 1'b1, aboveHigh)
        setFill(300, 20);
        `CHECK("single pause", 8'h01, pauseCount)
        setFill(128, 4);
        `CHECK("at low", 8'h01, pauseCount)
        setFill(127, 4);
        `CHECK("resume sent", 8'h02, pauseCount)
        `CHECK("resume time", 16'h0000, lastPause)
        `CHECK("below low", 1'b0, aboveHigh)
        // Transmitter off: a high level goes unanswered, no resume later
        linkMode.txEnable <= 1'b0;
        setFill(256, 4);
        `CHECK("tx off pause", 8'h02, pauseCount)
        setFill(0, 4);
        linkMode.txEnable <= 1'b1;
        setFill(0, 4);
        `CHECK("tx off resume", 8'h02, pauseCount)
        // A new pause time from the MAC is carried by the next pause
        pauseTimeValue <= 16'h00A5;
        setFill(256, 4);
        `CHECK("second pause", 16'h00A5, lastPause)
        setFill(0, 4);
        `CHECK("second resume", 8'h04, pauseCount)
        // Bits 3:1 do nothing in full duplex
        regWrite(32'h0004020E);
        setFill(256, 4);
        jamLen(3'h7, n);
        `CHECK("fd type bits", 8'h04, pauseCount)
        `CHECK("fd no jam", 0, n)
        // Half duplex: each type bit jams only its own frame type
        linkMode.fullDuplex <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            regWrite(32'h00040200 | (32'h2 << i));
            jamLen(3'(1 << ((i + 1) % 3)), n);
            `CHECK("other type", 0, n)
            jamLen(3'(1 << i), n);
            `CHECK("type jam", durCycles(0, 1'b1), n)
        end
        // Any frame: jam on preamble, length per duration code
        for (int c = 0; c < 5; c++) begin
            regWrite(32'h00040201 | 32'(c << 4));
            jamLen(3'h0, n);
            `CHECK("jam length", durCycles(c, 1'b1), n)
        end
        linkMode.speed100 <= 1'b0;
        regWrite(32'h00040201);
        jamLen(3'h0, n);
        `CHECK("slow jam", durCycles(0, 1'b0), n)
        linkMode.txEnable <= 1'b0;
        jamLen(3'h0, n);
        `CHECK("tx off jam", 0, n)
        linkMode.txEnable <= 1'b1;
        setFill(0, 4);
        jamLen(3'h0, n);
        `CHECK("low fill jam", 0, n)
        tally_and_finish();
    end
endmodule // testbench
